// File: bench/rwl_bench.sv
`timescale 1ns/1ps
module register_write_lock_bench;
  // ----
  // signals and helpers
  // ----
  localparam logic [31:0] LK_S = 32'h4000_0100;
  localparam logic [31:0] LK_NS = 32'h5000_0100;
  localparam logic [31:0] VIEWS [5] = '{32'h4000_0008, 32'h5000_0008, 32'h4000_0200,
    32'h4004_0000, 32'h5005_1000};
  localparam logic [23:0] BAD [3] = '{24'h591677, 24'h165988, 24'h598816};
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, unlocked_sec, unlocked_ns;
  logic [31:0] paddr, pwdata, prdata, rd, seed;
  logic [rwl_pkg::NPROT-1:0][31:0] prot_q;
  logic [31:0] mdl [rwl_pkg::NPROT];
  logic er, m_s, m_ns;
  int fail_count, n_checks;
  rwl_core dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .prot_q(prot_q), .unlocked_sec(unlocked_sec), .unlocked_ns(unlocked_ns));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int pidx(input logic [31:0] a);
    for (int i = 0; i < rwl_pkg::NPROT; i++) begin
      if (rwl_pkg::PROT_ADDR[i][27:0] == a[27:0]) return i;
    end
    return 0;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic key(input logic [31:0] a, input logic [23:0] k);
    for (int j = 2; j >= 0; j--) apb(1'b1, a, {24'h0, k[j*8 +: 8]});
  endtask
  task automatic wall();
    logic [31:0] d;
    for (int v = 0; v < 5; v++) begin
      d = rnd();
      apb(1'b1, VIEWS[v], d);
      if (VIEWS[v][28] ? m_ns : m_s) mdl[pidx(VIEWS[v])] = d;
    end
  endtask
  task automatic cmp(input string what);
    for (int i = 0; i < rwl_pkg::NPROT; i++) check(what, prot_q[i], mdl[i]);
    check("unlocked_sec", {31'h0, unlocked_sec}, {31'h0, m_s});
    check("unlocked_ns", {31'h0, unlocked_ns}, {31'h0, m_ns});
    $display("test %s done", what);
  endtask
  task automatic stat(input logic [31:0] a, input logic exp);
    apb(1'b0, a, 32'h0);
    check("lock status", rd, {31'h0, exp});
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    seed = 32'h0001_584f;
    {nrst, psel, penable, pwrite, m_s, m_ns} = 6'h0;
    {paddr, pwdata} = 64'h0;
    fail_count = 0;
    n_checks = 0;
    foreach (mdl[i]) mdl[i] = 32'h0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    wall();
    cmp("locked after reset");
    stat(LK_S, 1'b0);
    for (int b = 0; b < 3; b++) key(LK_S, BAD[b]);
    key(LK_S, 24'h005916);
    wall();
    apb(1'b1, LK_S, 32'h0000_0088);
    key(LK_S, 24'h005916);
    apb(1'b1, LK_NS, 32'h0000_0088);
    cmp("aborted keys");
    key(LK_S, 24'h000059);
    key(LK_S, 24'h591688);
    {m_s, m_ns} = 2'h3;
    wall();
    cmp("secure unlock");
    stat(LK_S, 1'b1);
    stat(LK_NS, 1'b1);
    apb(1'b1, LK_S, rnd());
    {m_s, m_ns} = 2'h0;
    wall();
    cmp("relock");
    key(LK_NS, 24'h005916);
    key(LK_NS, 24'h591688);
    m_ns = 1'b1;
    wall();
    cmp("alias unlock");
    stat(LK_S, 1'b0);
    stat(LK_NS, 1'b1);
    apb(1'b1, LK_NS, rnd());
    m_ns = 1'b0;
    cmp("alias relock");
    apb(1'b1, 32'h5000_0200, rnd());
    check("pslverr", {31'h0, er}, 32'h1);
    apb(1'b0, 32'h4005_1000, 32'h0);
    check("pslverr", {31'h0, er}, 32'h1);
    apb(1'b0, 32'h5000_0008, 32'h0);
    check("read back", rd, mdl[0]);
    check("pslverr", {31'h0, er}, 32'h0);
    $display("test views done");
    key(LK_S, 24'h591688);
    {m_s, m_ns} = 2'h3;
    wall();
    cmp("unlock before reset");
    nrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    {m_s, m_ns} = 2'h0;
    foreach (mdl[i]) mdl[i] = 32'h0;
    cmp("mid-run reset");
    stat(LK_S, 1'b0);
    close_out();
  end
endmodule // register_write_lock_bench

// File: common/rwl_pkg.sv
// Summary of operation
// [RL1] Protected registers ignore writes from power-on reset until unlocked.
// [RL2] Unlock key is bytes 59h, 16h, 88h written in order to lock register.
// [RL3] Wrong value, wrong order or write elsewhere aborts a partial key.
// [RL4] After a full key, protected registers accept ordinary writes.
// [RL5] Any write to the lock register while unlocked locks again.
// [RL6] Address bit 28 low means secure access, high means non-secure.
// [RL7] Key through secure lock register unlocks secure and non-secure registers.
// [RL8] Key through non-secure alias unlocks only non-secure registers.
// [RL9] Protected set is a fixed list of system control registers.
// [RL10] Non-secure copy sits at secure address with leading nibble 5.
// [RL11] Register security view follows its peripheral's security type.
// [RL12] After an abort the sequence waits for the first key byte again.
// [RL13] Lock register read returns 1 in bit 0 while the view it is read through is unlocked.
package rwl_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam int NS_BIT = 28;
  localparam logic [2:0] REGION_HI = 3'h2;
  localparam logic [3:0] SEC_NIB = 4'h4;
  localparam logic [31:0] LOCK_KEY_SEC_ADDR = 32'h4000_0100;
  localparam logic [31:0] LOCK_KEY_NS_ADDR = 32'h5000_0100;
  localparam int NPROT = 4;
  localparam int IDXW = 2;
  // peripheral_reset_control, clock_power_control, watchdog_control, timer_control
  localparam logic [31:0] PROT_ADDR [NPROT] = '{
    32'h4000_0008, 32'h4000_0200, 32'h4004_0000, 32'h4005_1000};
  // view bit 0: secure copy present, bit 1: non-secure copy present
  localparam int VIEW_S = 0;
  localparam int VIEW_NS = 1;
  localparam logic [1:0] PROT_VIEW [NPROT] = '{2'h3, 2'h1, 2'h1, 2'h2};
  localparam logic [31:0] PROT_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // key and status
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY1 = 8'h59;
  localparam logic [7:0] KEY2 = 8'h16;
  localparam logic [7:0] KEY3 = 8'h88;
  localparam int STAT_UNLOCK_BIT = 0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_GOT1, SEQ_GOT2} rwl_seq_t;

  typedef struct packed {
    logic lock;
    logic prot;
    logic [IDXW-1:0] idx;
    logic ns;
  } rwl_dec_t;

endpackage

// File: design/rwl_core.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module rwl_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // protected control values
  output logic [rwl_pkg::NPROT-1:0][31:0] prot_q,
  // lock state
  output logic unlocked_sec,
  output logic unlocked_ns
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic rwl_pkg::rwl_dec_t rwl_decode(input logic [31:0] a);
    rwl_pkg::rwl_dec_t d;
    logic [31:0] base;
    logic valid;
    d = '0;
    d.ns = a[rwl_pkg::NS_BIT]; // see [RL6]
    valid = (a[31:29] == rwl_pkg::REGION_HI);
    base = {rwl_pkg::SEC_NIB, a[27:0]}; // see [RL10]
    if (valid && base == rwl_pkg::LOCK_KEY_SEC_ADDR) begin
      d.lock = 1'b1;
    end
    for (int i = 0; i < rwl_pkg::NPROT; i++) begin
      // see [RL9] see [RL11]
      if (valid && base == rwl_pkg::PROT_ADDR[i] && rwl_pkg::PROT_VIEW[i][d.ns]) begin
        d.prot = 1'b1;
        d.idx = rwl_pkg::IDXW'(i);
      end
    end
    return d;
  endfunction

  rwl_pkg::rwl_dec_t dec;
  rwl_pkg::rwl_seq_t seq_ff;
  logic seq_ns_ff;
  logic unlock_s_ff;
  logic unlock_ns_ff;
  logic acc;
  logic wr;
  logic any_unl;
  logic wr_ok;
  logic [7:0] key;
  logic [31:0] prdata_ff;
  logic [31:0] prot_ff [rwl_pkg::NPROT];

  assign dec = rwl_decode(paddr);
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign key = pwdata[7:0];
  assign any_unl = unlock_s_ff | unlock_ns_ff;
  // see [RL7] see [RL8]
  assign wr_ok = dec.ns ? any_unl : unlock_s_ff;

  // ----------------------------------------------------------------
  // key sequence
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      seq_ff <= rwl_pkg::SEQ_IDLE;
      seq_ns_ff <= 1'b0;
    end else if (wr) begin
      if (!dec.lock || any_unl) begin
        seq_ff <= rwl_pkg::SEQ_IDLE; // see [RL3]
      end else begin
        case (seq_ff)
          rwl_pkg::SEQ_IDLE: begin
            if (key == rwl_pkg::KEY1) begin // see [RL2]
              seq_ff <= rwl_pkg::SEQ_GOT1;
              seq_ns_ff <= dec.ns;
            end
          end
          rwl_pkg::SEQ_GOT1: begin
            if (key == rwl_pkg::KEY2 && dec.ns == seq_ns_ff) begin
              seq_ff <= rwl_pkg::SEQ_GOT2;
            end else if (key == rwl_pkg::KEY1) begin
              seq_ff <= rwl_pkg::SEQ_GOT1; // see [RL12]
              seq_ns_ff <= dec.ns;
            end else begin
              seq_ff <= rwl_pkg::SEQ_IDLE; // see [RL3]
            end
          end
          default: begin
            if (key == rwl_pkg::KEY1 && !(dec.ns == seq_ns_ff && key == rwl_pkg::KEY3)) begin
              seq_ff <= rwl_pkg::SEQ_GOT1; // see [RL12]
              seq_ns_ff <= dec.ns;
            end else begin
              seq_ff <= rwl_pkg::SEQ_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // lock flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      unlock_s_ff <= 1'b0; // see [RL1]
      unlock_ns_ff <= 1'b0;
    end else if (wr && dec.lock) begin
      if (any_unl) begin
        unlock_s_ff <= 1'b0; // see [RL5]
        unlock_ns_ff <= 1'b0;
      end else if (seq_ff == rwl_pkg::SEQ_GOT2 && key == rwl_pkg::KEY3
                   && dec.ns == seq_ns_ff) begin
        if (dec.ns) begin
          unlock_ns_ff <= 1'b1; // see [RL8]
        end else begin
          unlock_s_ff <= 1'b1; // see [RL7]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // protected registers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < rwl_pkg::NPROT; g++) begin : g_prot
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        prot_ff[g] <= rwl_pkg::PROT_RESET;
      end else if (wr && dec.prot && dec.idx == rwl_pkg::IDXW'(g) && wr_ok) begin
        prot_ff[g] <= pwdata; // see [RL1] see [RL4]
      end
    end
  end

  always_comb begin
    for (int i = 0; i < rwl_pkg::NPROT; i++) begin
      prot_q[i] = prot_ff[i];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      if (dec.lock) begin
        prdata_ff[rwl_pkg::STAT_UNLOCK_BIT] <= wr_ok; // see [RL13]
      end else if (dec.prot) begin
        prdata_ff <= prot_q[dec.idx];
      end
    end
  end

  assign pready = 1'b1;
  assign pslverr = acc & ~(dec.lock | dec.prot);
  assign prdata = prdata_ff;
  assign unlocked_sec = unlock_s_ff;
  assign unlocked_ns = any_unl;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (rwl_pkg::NPROT < 1 || rwl_pkg::NPROT > (1 << rwl_pkg::IDXW)) begin : g_bad_cfg
    $error("protected list does not fit the index width");
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  relock_any_write_a: assert property ( // see [RL5]
    wr && dec.lock && any_unl |=> !unlocked_sec && !unlocked_ns)
    else $error("lock write while unlocked did not relock");

  locked_write_drop_a: assert property ( // see [RL1]
    wr && dec.prot && !dec.ns && !unlock_s_ff |=> $stable(prot_q))
    else $error("protected register changed while locked");

  key_unlocks_sec_a: assert property ( // see [RL2]
    seq_ff == rwl_pkg::SEQ_GOT2 && !seq_ns_ff && !any_unl && wr && dec.lock
    && !dec.ns && key == rwl_pkg::KEY3 |=> unlocked_sec && unlocked_ns)
    else $error("full secure key did not unlock");

  abort_other_addr_a: assert property ( // see [RL3]
    seq_ff != rwl_pkg::SEQ_IDLE && wr && !dec.lock |=> seq_ff == rwl_pkg::SEQ_IDLE)
    else $error("write elsewhere did not abort key");

  open_write_lands_a: assert property ( // see [RL4]
    wr && dec.prot && wr_ok |=> prot_q[$past(dec.idx)] == $past(pwdata))
    else $error("unlocked write not stored");

  ns_key_no_sec_a: assert property ( // see [RL8]
    wr && dec.lock && dec.ns |=> !$rose(unlocked_sec))
    else $error("alias key unlocked secure registers");

  ns_view_secure_a: assert property ( // see [RL11]
    acc && paddr[rwl_pkg::NS_BIT] && paddr[27:0] == rwl_pkg::PROT_ADDR[1][27:0]
    && paddr[31:29] == rwl_pkg::REGION_HI |-> pslverr)
    else $error("secure-only register seen through alias");

  status_read_a: assert property ( // see [RL13]
    psel && !penable && !pwrite && dec.lock && !dec.ns
    |=> prdata == {31'h0, unlocked_sec})
    else $error("lock status read wrong");

  restart_key_a: assert property ( // see [RL12]
    seq_ff == rwl_pkg::SEQ_GOT1 && wr && dec.lock && !any_unl
    && key == rwl_pkg::KEY1 |=> seq_ff == rwl_pkg::SEQ_GOT1 ##1 seq_ff != rwl_pkg::SEQ_GOT2
    || $past(wr))
    else $error("key restart lost");

  // ----------------------------------------------------------------
  // key sequence, write and status checks
  // ----------------------------------------------------------------
  first_key_byte_a: assert property ( // see [RL2]
    seq_ff == rwl_pkg::SEQ_IDLE && wr && dec.lock && !any_unl && key == rwl_pkg::KEY1
    |=> seq_ff == rwl_pkg::SEQ_GOT1)
    else $error("first key byte not taken");

  second_key_byte_a: assert property ( // see [RL2]
    seq_ff == rwl_pkg::SEQ_GOT1 && wr && dec.lock && !any_unl && key == rwl_pkg::KEY2
    && dec.ns == seq_ns_ff |=> seq_ff == rwl_pkg::SEQ_GOT2)
    else $error("second key byte not taken");

  key_only_unlock_a: assert property ( // see [RL2]
    !any_unl && !(wr && dec.lock && seq_ff == rwl_pkg::SEQ_GOT2 && key == rwl_pkg::KEY3)
    |=> !unlocked_ns)
    else $error("unlocked without the full key");

  wrong_byte_abort_a: assert property ( // see [RL3]
    seq_ff == rwl_pkg::SEQ_GOT1 && wr && dec.lock && !any_unl
    && key != rwl_pkg::KEY2 && key != rwl_pkg::KEY1 |=> seq_ff == rwl_pkg::SEQ_IDLE)
    else $error("wrong key byte did not abort");

  mixed_view_abort_a: assert property ( // see [RL3]
    seq_ff == rwl_pkg::SEQ_GOT2 && wr && dec.lock && !any_unl && dec.ns != seq_ns_ff
    |=> !unlocked_ns)
    else $error("key split across views unlocked");

  ns_key_unlocks_a: assert property ( // see [RL8]
    seq_ff == rwl_pkg::SEQ_GOT2 && seq_ns_ff && !any_unl && wr && dec.lock
    && dec.ns && key == rwl_pkg::KEY3 |=> unlocked_ns && !unlocked_sec)
    else $error("full alias key did not unlock non-secure only");

  unlocked_idle_a: assert property ( // see [RL5]
    unlocked_ns |-> seq_ff == rwl_pkg::SEQ_IDLE)
    else $error("key bytes counted while unlocked");

  ns_locked_drop_a: assert property ( // see [RL1]
    wr && dec.prot && dec.ns && !any_unl |=> $stable(prot_q))
    else $error("non-secure view changed while locked");

  write_only_change_a: assert property ( // see [RL4]
    !wr |=> $stable(prot_q))
    else $error("protected register changed without a write");

  ns_status_read_a: assert property ( // see [RL13]
    psel && !penable && !pwrite && dec.lock && dec.ns
    |=> prdata == {31'h0, unlocked_ns})
    else $error("alias lock status read wrong");

  // ----------------------------------------------------------------
  // address map checks
  // ----------------------------------------------------------------
  lock_addr_mapped_a: assert property ( // see [RL7] see [RL8]
    acc && (paddr == rwl_pkg::LOCK_KEY_SEC_ADDR || paddr == rwl_pkg::LOCK_KEY_NS_ADDR)
    |-> !pslverr)
    else $error("lock register refused");

  listed_reg_mapped_a: assert property ( // see [RL9]
    acc && paddr == rwl_pkg::PROT_ADDR[0] |-> !pslverr)
    else $error("listed register refused");

  ns_copy_mapped_a: assert property ( // see [RL10]
    acc && paddr == {4'h5, rwl_pkg::PROT_ADDR[0][27:0]} |-> !pslverr)
    else $error("non-secure copy refused");

  sec_view_ns_only_a: assert property ( // see [RL11]
    acc && !paddr[rwl_pkg::NS_BIT] && paddr[27:0] == rwl_pkg::PROT_ADDR[3][27:0]
    && paddr[31:29] == rwl_pkg::REGION_HI |-> pslverr)
    else $error("non-secure-only register seen through secure view");

  err_read_zero_a: assert property ( // see [RL11]
    psel && !penable && !pwrite && !dec.lock && !dec.prot |=> prdata == 32'h0000_0000)
    else $error("refused read returned data");

  cov_sec_unlock_c: cover property ($rose(unlocked_sec));
  cov_ns_unlock_c: cover property ($rose(unlocked_ns) && !unlocked_sec);
  cov_abort_c: cover property (seq_ff == rwl_pkg::SEQ_GOT2 ##1 seq_ff == rwl_pkg::SEQ_IDLE
    && !any_unl);
  cov_relock_c: cover property ($fell(unlocked_ns));
  cov_restart_c: cover property (seq_ff == rwl_pkg::SEQ_GOT1 ##1 seq_ff == rwl_pkg::SEQ_GOT1);

endmodule // rwl_core
